//--- rtl/pals_pkg.sv
// Package: register map, field positions, reset values and timing counts for auto-negotiation.
package pals_pkg;
  // ---------------------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------------------
  localparam logic [7:0] PALS_OFF_CONTROL = 8'h80;
  localparam logic [7:0] PALS_OFF_STATUS = 8'h84;
  localparam logic [7:0] PALS_OFF_ADVERT = 8'h90;
  localparam logic [7:0] PALS_OFF_PARTNER = 8'h94;
  localparam logic [7:0] PALS_OFF_EXPANSION = 8'h98;
  localparam logic [7:0] PALS_OFF_RESULT = 8'hc0;
  // ---------------------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------------------
  localparam int PALS_CTL_SPEED = 13;
  localparam int PALS_CTL_NEG_EN = 12;
  localparam int PALS_CTL_RESTART = 9;
  localparam int PALS_CTL_DUPLEX = 8;
  localparam int PALS_ADV_ABIL_LO = 5;
  localparam int PALS_ADV_ABIL_HI = 8;
  // ---------------------------------------------------------------------------
  // Reset and constant values
  // ---------------------------------------------------------------------------
  localparam logic [15:0] PALS_ADV_RESET = 16'h01e1;
  localparam logic [15:0] PALS_STATUS_CAPS = 16'h7849;
  localparam logic [15:0] PALS_PD_FAST_WORD = 16'h0081;
  localparam logic [15:0] PALS_PD_SLOW_WORD = 16'h0021;
  localparam logic [15:0] PALS_EXP_LOCAL_NP = 16'h0004;
  // ---------------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------------
  localparam int PALS_CLK_HZ = 20000000;
  localparam int PALS_BREAK_MS = 1500;
  localparam int PALS_BREAK_CYCLES = PALS_BREAK_MS * (PALS_CLK_HZ / 1000);
  localparam int PALS_SIGDET_US = 500;
  localparam int PALS_SIGDET_CYCLES = PALS_SIGDET_US * (PALS_CLK_HZ / 1000000);
  localparam int PALS_NLP_COUNT = 7;
  localparam int PALS_LINK_LOSS_MS = 50;
  localparam int PALS_LINK_LOSS_CYCLES = PALS_LINK_LOSS_MS * (PALS_CLK_HZ / 1000);
  typedef enum logic [2:0] {
    PALS_ST_IDLE, PALS_ST_BREAK, PALS_ST_NEGOTIATE, PALS_ST_DONE
  } pals_state_e;
endpackage : pals_pkg

//--- rtl/pals_top.sv
// Auto-negotiation control, status registers and link indicators of the 10/100 PHY.
//
// Decided for this implementation: the plain strobed port.
`timescale 1ns/10ps
module pals_top #(
  parameter int BREAK_CYCLES = pals_pkg::PALS_BREAK_CYCLES,
  parameter int SIGDET_CYCLES = pals_pkg::PALS_SIGDET_CYCLES,
  parameter int LINK_LOSS_CYCLES = pals_pkg::PALS_LINK_LOSS_CYCLES
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire logic [3:0] strap_abilities,
  input wire logic strap_neg_en,
  input wire logic fast_signal_detect,
  input wire logic slow_link_pulse,
  input wire logic slow_valid_packet,
  input wire logic rx_activity,
  input wire logic tx_activity,
  input wire logic page_valid,
  input wire logic [15:0] page_word,
  input wire logic partner_negotiates,
  output logic [15:0] flp_word,
  output logic flp_send,
  output logic tx_silence,
  output logic link_speed_100,
  output logic link_full_duplex,
  output logic activity_indicator_n,
  output logic fast_link_indicator_n,
  output logic slow_link_indicator_n
);
  import pals_pkg::*;

  // ---------------------------------------------------------------------------
  // Overview
  // ---------------------------------------------------------------------------
  // The block has four parts: pin synchronisers, link qualification, the register
  // file and the negotiation sequencer. Every output is registered at the end.
  // The line side is abstract: the receivers report signal detect, link pulses,
  // valid packets and activity as levels, and a received page arrives as a word
  // with a one-cycle valid strobe on this clock.
  // All pin inputs pass two flip-flops, so every decision on them lags the pins
  // by two cycles. The page interface already lives on this clock and is used raw.
  // The straps are sampled once, after the synchronisers have filled. Sampling them
  // in the reset branch would need non-constant reset values and would catch a
  // pin that had not settled.
  // Negotiation runs idle, break, negotiate and done. Any request to negotiate
  // goes through break, so the partner always sees the line fall silent first.
  // The break counter is 32 bits wide because the real break interval is tens of
  // millions of cycles at this clock. Tests shorten it through the parameter.
  // Parallel detection is handled inside the negotiate state. A single qualified
  // link completes at once with a fixed partner word. Two links at once hold the
  // state and keep raising the fault flag until one of them goes away.
  // The resolved mode is recomputed from the two ability words every cycle. It is
  // masked by the valid flag, so the speed and duplex outputs read zero while
  // negotiation is running.
  // In forced mode the speed and duplex bits of the control register drive the
  // outputs directly and the sequencer is parked in idle.
  // Restart writes are only honoured after a completed negotiation. A write to
  // the restart bit at any other time is dropped, which also keeps a stray
  // restart from cutting an exchange short.
  // Clearing the enable bit parks the sequencer; setting it again requests a
  // fresh negotiation. This also covers a device that came up in forced mode.
  // The fault and page flags clear on a read of the expansion register. When a
  // read and a new event fall in one cycle the event wins, so nothing is lost.
  // The clock enable freezes every register, including the synchronisers and the
  // timers, so a frozen block resumes exactly where it stopped.
  // Reads return data in the cycle after the strobe and zero otherwise, so the
  // read data bus can be combined with other slaves by a plain or.
  // Writes to unmapped offsets are ignored and reads of them return zero.
  // Only the speed, enable and duplex bits of the control register are stored.
  // The restart bit reads one while a request is pending and clears itself when
  // the sequencer enters the break.
  // The link timers use the same 32-bit width for simplicity; they are small
  // compared with the break counter and cost little.
  // Limitation: next pages are not sequenced here. Each valid page in the negotiate state overwrites
  // the partner word, and completion follows the first page from a negotiating
  // partner.

  // ---------------------------------------------------------------------------
  // Elaboration checks
  // ---------------------------------------------------------------------------
  if (BREAK_CYCLES < 1 || SIGDET_CYCLES < 1 || LINK_LOSS_CYCLES < 1) begin : g_bad_timing
    $error("pals_top: timing counts must be at least one cycle");
  end

  // ---------------------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------------------
  // Order: strap_neg_en, strap[3:0], sigdet, pulse, packet, rx, tx.
  localparam int NSYNC = 10;
  logic [NSYNC-1:0] sync1_reg;
  logic [NSYNC-1:0] sync2_reg;
  wire [NSYNC-1:0] pin_raw = {strap_neg_en, strap_abilities, fast_signal_detect,
                              slow_link_pulse, slow_valid_packet, rx_activity, tx_activity};
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else if (ce) begin
      sync1_reg <= pin_raw;
      sync2_reg <= sync1_reg;
    end
  end
  wire s_strap_en = sync2_reg[9];
  wire [3:0] s_strap_ab = sync2_reg[8:5];
  wire s_sigdet = sync2_reg[4];
  wire s_pulse = sync2_reg[3];
  wire s_packet = sync2_reg[2];
  wire s_act = sync2_reg[1] | sync2_reg[0];

  // ---------------------------------------------------------------------------
  // Link detection
  // ---------------------------------------------------------------------------
  // The straps are caught after the synchroniser has filled, never by the reset itself.
  logic [1:0] boot_reg;
  wire boot_load = (boot_reg == 2'd2);
  logic [31:0] sig_cnt_reg;
  logic fast_link_reg;
  logic [2:0] nlp_cnt_reg;
  logic pulse_d_reg;
  logic [31:0] loss_cnt_reg;
  logic slow_link_reg;
  wire pulse_rise = s_pulse & ~pulse_d_reg;
  wire slow_event = pulse_rise | s_packet;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      boot_reg <= 2'd0;
      sig_cnt_reg <= '0;
      fast_link_reg <= 1'b0;
      nlp_cnt_reg <= '0;
      pulse_d_reg <= 1'b0;
      loss_cnt_reg <= '0;
      slow_link_reg <= 1'b0;
    end else if (ce) begin
      if (boot_reg != 2'd3) begin
        boot_reg <= boot_reg + 2'd1;
      end
      pulse_d_reg <= s_pulse;
      if (!s_sigdet) begin
        sig_cnt_reg <= '0;
        fast_link_reg <= 1'b0;
      end else if (sig_cnt_reg >= 32'(SIGDET_CYCLES - 1)) begin
        fast_link_reg <= 1'b1;
      end else begin
        sig_cnt_reg <= sig_cnt_reg + 32'd1;
      end
      if (slow_event) begin
        loss_cnt_reg <= '0;
        if (s_packet || nlp_cnt_reg == 3'(PALS_NLP_COUNT - 1)) begin
          slow_link_reg <= 1'b1;
        end else begin
          nlp_cnt_reg <= nlp_cnt_reg + 3'd1;
        end
      end else if (loss_cnt_reg >= 32'(LINK_LOSS_CYCLES - 1)) begin
        slow_link_reg <= 1'b0;
        nlp_cnt_reg <= '0;
        loss_cnt_reg <= '0;
      end else begin
        loss_cnt_reg <= loss_cnt_reg + 32'd1;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------------------
  logic [15:0] ctl_reg;
  logic [15:0] adv_reg;
  logic [15:0] partner_reg;
  logic pd_fault_reg;
  logic page_rx_reg;
  logic partner_an_reg;
  logic complete_reg;
  logic restart_req_reg;
  pals_state_e state_reg;
  logic [31:0] brk_cnt_reg;

  wire wr_ctl = reg_wr && reg_addr == PALS_OFF_CONTROL;
  wire wr_adv = reg_wr && reg_addr == PALS_OFF_ADVERT;
  wire rd_exp = reg_rd && reg_addr == PALS_OFF_EXPANSION;
  wire neg_en = ctl_reg[PALS_CTL_NEG_EN];
  // A cleared enable stops negotiation; the next set re-arms it after the break.
  wire en_rise = wr_ctl && reg_wdata[PALS_CTL_NEG_EN] && !neg_en;
  wire restart_wr = wr_ctl && reg_wdata[PALS_CTL_RESTART] && complete_reg;

  // Parallel detection watches both receivers at once.
  wire any_link = fast_link_reg | slow_link_reg;
  wire one_link = fast_link_reg ^ slow_link_reg;

  // Highest common mode from both ability words.
  wire [3:0] common = adv_reg[8:5] & partner_reg[8:5];
  wire res_100 = common[3] | common[2];
  wire res_full = common[3] | (~common[2] & common[1]);

  // Loss only counts once a link has been seen in the done state. A page completes
  // before the receiver has qualified its link, and without this guard the gap between
  // the two would look like a lost link and throw the block straight back into break.
  logic link_seen_reg;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      link_seen_reg <= 1'b0;
    end else if (ce) begin
      link_seen_reg <= (state_reg == PALS_ST_DONE) && (link_seen_reg || any_link);
    end
  end
  wire lost = state_reg == PALS_ST_DONE && link_seen_reg && !any_link;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctl_reg <= '0;
      adv_reg <= PALS_ADV_RESET;
      restart_req_reg <= 1'b0;
    end else if (ce) begin
      if (boot_load) begin
        ctl_reg[PALS_CTL_NEG_EN] <= s_strap_en;
        adv_reg[PALS_ADV_ABIL_HI:PALS_ADV_ABIL_LO] <= s_strap_ab;
        restart_req_reg <= s_strap_en;
      end else begin
        if (wr_ctl) begin
          ctl_reg <= reg_wdata & 16'h3100;
        end
        if (wr_adv) begin
          adv_reg <= reg_wdata;
        end
        if (restart_wr || en_rise || lost) begin
          restart_req_reg <= 1'b1;
        end else if (state_reg == PALS_ST_BREAK) begin
          restart_req_reg <= 1'b0;
        end
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Negotiation sequencer
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= PALS_ST_IDLE;
      brk_cnt_reg <= '0;
      complete_reg <= 1'b0;
      partner_reg <= '0;
      pd_fault_reg <= 1'b0;
      page_rx_reg <= 1'b0;
      partner_an_reg <= 1'b0;
    end else if (ce) begin
      if (rd_exp) begin
        page_rx_reg <= 1'b0;
        pd_fault_reg <= 1'b0;
      end
      if (!neg_en) begin
        state_reg <= PALS_ST_IDLE;
        complete_reg <= 1'b0;
      end else begin
        unique case (state_reg)
          PALS_ST_IDLE: begin
            if (restart_req_reg) begin
              state_reg <= PALS_ST_BREAK;
              brk_cnt_reg <= '0;
              complete_reg <= 1'b0;
            end
          end
          PALS_ST_BREAK: begin
            if (brk_cnt_reg >= 32'(BREAK_CYCLES - 1)) begin
              state_reg <= PALS_ST_NEGOTIATE;
            end else begin
              brk_cnt_reg <= brk_cnt_reg + 32'd1;
            end
          end
          PALS_ST_NEGOTIATE: begin
            if (page_valid) begin
              partner_reg <= page_word;
              page_rx_reg <= 1'b1;
              partner_an_reg <= partner_negotiates;
              if (partner_negotiates) begin
                state_reg <= PALS_ST_DONE;
                complete_reg <= 1'b1;
              end
            end else if (any_link && !one_link) begin
              pd_fault_reg <= 1'b1;
            end else if (one_link) begin
              partner_reg <= fast_link_reg ? PALS_PD_FAST_WORD : PALS_PD_SLOW_WORD;
              partner_an_reg <= 1'b0;
              state_reg <= PALS_ST_DONE;
              complete_reg <= 1'b1;
            end
          end
          PALS_ST_DONE: begin
            if (restart_req_reg) begin
              state_reg <= PALS_ST_BREAK;
              brk_cnt_reg <= '0;
              complete_reg <= 1'b0;
            end
          end
          default: state_reg <= PALS_ST_IDLE;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Read mux and outputs
  // ---------------------------------------------------------------------------
  wire spd = neg_en ? res_100 : ctl_reg[PALS_CTL_SPEED];
  wire dup = neg_en ? res_full : ctl_reg[PALS_CTL_DUPLEX];
  wire res_valid = !neg_en || complete_reg;
  wire [15:0] ctl_view = ctl_reg | {6'd0, restart_req_reg, 9'd0};
  wire [15:0] stat_view = PALS_STATUS_CAPS
                        | {10'd0, complete_reg, partner_reg[13], 1'b0, any_link, 2'b00};
  wire [15:0] exp_view = PALS_EXP_LOCAL_NP
                       | {11'd0, pd_fault_reg, partner_reg[15], 1'b0, page_rx_reg,
                          partner_an_reg};
  wire [15:0] res_view = {11'd0, complete_reg, 1'b0, dup & res_valid,
                          spd & res_valid, any_link};
  logic [15:0] rd_mux;
  always_comb begin
    unique case (reg_addr)
      PALS_OFF_CONTROL: rd_mux = ctl_view;
      PALS_OFF_STATUS: rd_mux = stat_view;
      PALS_OFF_ADVERT: rd_mux = adv_reg;
      PALS_OFF_PARTNER: rd_mux = partner_reg;
      PALS_OFF_EXPANSION: rd_mux = exp_view;
      PALS_OFF_RESULT: rd_mux = res_view;
      default: rd_mux = 16'h0000;
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      reg_rdata <= '0;
      flp_word <= '0;
      flp_send <= 1'b0;
      tx_silence <= 1'b0;
      link_speed_100 <= 1'b0;
      link_full_duplex <= 1'b0;
      activity_indicator_n <= 1'b1;
      fast_link_indicator_n <= 1'b1;
      slow_link_indicator_n <= 1'b1;
    end else if (ce) begin
      reg_rdata <= reg_rd ? rd_mux : 16'h0000;
      flp_word <= adv_reg;
      flp_send <= state_reg == PALS_ST_NEGOTIATE;
      tx_silence <= state_reg == PALS_ST_BREAK;
      link_speed_100 <= spd & res_valid;
      link_full_duplex <= dup & res_valid;
      activity_indicator_n <= ~s_act;
      fast_link_indicator_n <= ~(fast_link_reg & s_sigdet);
      slow_link_indicator_n <= ~slow_link_reg;
    end
  end
endmodule : pals_top

//--- verif/pals_link_partner.sv
// Link partner model: base page, parallel-detect line signals and receive activity.
`timescale 1ns/10ps
module pals_link_partner (
  input wire logic clk,
  input wire logic [2:0] mode,
  input wire logic [15:0] word,
  input wire logic [4:0] dly,
  input wire logic flp_send,
  input wire logic tx_silence,
  output logic fast_signal_detect,
  output logic slow_link_pulse,
  output logic rx_activity,
  output logic page_valid,
  output logic [15:0] page_word,
  output logic partner_negotiates
);
  logic [4:0] cnt = '0;
  logic [2:0] ph = '0;
  logic sent = 1'b0;
  initial page_valid = 1'b0;
  initial page_word = '0;
  // Mode 1 negotiates, 2 shows a fast line only, 3 a slow line only, 4 both lines.
  assign partner_negotiates = mode == 3'd1;
  assign fast_signal_detect = mode == 3'd2 || mode == 3'd4 || (mode == 3'd1 && sent);
  assign slow_link_pulse = (mode == 3'd3 || mode == 3'd4) && ph[2];
  assign rx_activity = mode != 3'd0 && ph[0];
  always @(posedge clk) begin
    ph <= ph + 3'd1;
    page_valid <= 1'b0;
    // A released word bus must not keep showing the last page.
    page_word <= page_word ^ 16'h5a5a;
    if (tx_silence) begin
      sent <= 1'b0;
      cnt <= '0;
    end else if (mode == 3'd1 && flp_send && !sent) begin
      cnt <= cnt + 5'd1;
      if (cnt == dly) begin
        page_valid <= 1'b1;
        page_word <= word;
        sent <= 1'b1;
      end
    end
  end
endmodule : pals_link_partner

//--- verif/pals_top_properties.sv
// Port-level assertions for the auto-negotiation block.
`timescale 1ns/10ps
module pals_top_properties #(
  parameter int BREAK_CYCLES = 20,
  parameter int SIGDET_CYCLES = 8,
  parameter int LINK_LOSS_CYCLES = 16
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic fast_signal_detect,
  input wire logic slow_link_pulse,
  input wire logic slow_valid_packet,
  input wire logic rx_activity,
  input wire logic tx_activity,
  input wire logic flp_send,
  input wire logic tx_silence,
  input wire logic activity_indicator_n,
  input wire logic fast_link_indicator_n,
  input wire logic slow_link_indicator_n
);
  // Raw run lengths; the design sees inputs two cycles late, so bounds keep slack.
  int det_cnt, sil_cnt, quiet_cnt;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      det_cnt <= 0;
      sil_cnt <= 0;
      quiet_cnt <= 0;
    end else begin
      det_cnt <= fast_signal_detect ? det_cnt + 1 : 0;
      sil_cnt <= tx_silence ? sil_cnt + 1 : 0;
      quiet_cnt <= (slow_link_pulse || slow_valid_packet) ? 0 : quiet_cnt + 1;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // A write may end a break early by disabling negotiation; only falls one or two cycles after a write are skipped.
  sequence break_end_s;
    $fell(tx_silence) && !$past(reg_wr) && !$past(reg_wr, 2);
  endsequence
  sequence resume_s;
    ##[0:3] flp_send;
  endsequence
  status_caps_a: assert property (
    $past(reg_rd) && $past(reg_addr) == 8'h84 |-> (reg_rdata & 16'hf849) == 16'h7849)
    else $error("status capability bits wrong");
  expansion_np_a: assert property (
    $past(reg_rd) && $past(reg_addr) == 8'h98 |-> reg_rdata[2])
    else $error("local next page bit not set");
  silence_quiet_a: assert property (tx_silence |-> !flp_send)
    else $error("bursts sent during break");
  break_len_a: assert property (
    break_end_s |-> (sil_cnt >= BREAK_CYCLES - 1 && sil_cnt <= BREAK_CYCLES + 1) ##0 resume_s)
    else $error("break length or resume wrong");
  fast_drop_a: assert property (!fast_signal_detect [*4] |=> fast_link_indicator_n)
    else $error("fast link indicator held");
  fast_wait_a: assert property (
    $fell(fast_link_indicator_n) |-> det_cnt >= SIGDET_CYCLES)
    else $error("fast link indicator early");
  activity_led_a: assert property (
    (rx_activity || tx_activity) [*3] |=> !activity_indicator_n)
    else $error("activity indicator missing");
  slow_loss_a: assert property (
    quiet_cnt > LINK_LOSS_CYCLES + 4 |-> slow_link_indicator_n)
    else $error("slow link indicator not released");
endmodule : pals_top_properties
bind pals_top pals_top_properties #(.BREAK_CYCLES(BREAK_CYCLES), .SIGDET_CYCLES(SIGDET_CYCLES),
  .LINK_LOSS_CYCLES(LINK_LOSS_CYCLES)) u_props (.clk, .rstn, .reg_addr, .reg_wr, .reg_rd,
  .reg_rdata, .fast_signal_detect, .slow_link_pulse, .slow_valid_packet, .rx_activity,
  .tx_activity, .flp_send, .tx_silence, .activity_indicator_n, .fast_link_indicator_n,
  .slow_link_indicator_n);

//--- verif/tb.sv
// Self-checking bench: registers, negotiation, parallel detect, forced mode.
`timescale 1ns/10ps
module tb;
  import pals_pkg::*;
  logic clk = 0, rstn = 0, reg_wr = 0, reg_rd = 0, tx_activity = 0, rd_d = 0, pkt = 0;
  logic [7:0] reg_addr = '0;
  logic [15:0] reg_wdata = '0, reg_rdata, flp_word, page_word, adv, pw = 16'h21e1;
  logic [3:0] strap_abilities = '0;
  logic [2:0] mode = '0;
  logic [4:0] dly = '0;
  logic fast_signal_detect, slow_link_pulse, rx_activity, page_valid, partner_negotiates;
  logic flp_send, tx_silence, link_speed_100, link_full_duplex;
  logic activity_indicator_n, fast_link_indicator_n, slow_link_indicator_n;
  logic [15:0] eq[$], mq[$];
  int miscompares = 0, n_tests = 0;
  always #25 clk = ~clk;
  pals_top #(.BREAK_CYCLES(20), .SIGDET_CYCLES(8), .LINK_LOSS_CYCLES(16)) dut (.clk, .rstn,
    .ce(1'b1), .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .strap_abilities,
    .strap_neg_en(1'b1), .fast_signal_detect, .slow_link_pulse, .slow_valid_packet(pkt),
    .rx_activity, .tx_activity, .page_valid, .page_word, .partner_negotiates, .flp_word,
    .flp_send, .tx_silence, .link_speed_100, .link_full_duplex, .activity_indicator_n,
    .fast_link_indicator_n, .slow_link_indicator_n);
  pals_link_partner partner (.clk, .mode, .word(pw), .dly, .flp_send, .tx_silence,
    .fast_signal_detect, .slow_link_pulse, .rx_activity, .page_valid, .page_word,
    .partner_negotiates);
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : print_verdict
  task automatic chk(input string nm, input logic [15:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_wr <= 1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 0;
  endtask : wr
  // The expected word is queued before the read; the monitor below compares it.
  task automatic rd(input logic [7:0] a, input logic [15:0] e, m);
    eq.push_back(e);
    mq.push_back(m);
    @(posedge clk);
    reg_rd <= 1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 0;
  endtask : rd
  task automatic wsig(input bit sil, input logic v);
    int i;
    #1;
    for (i = 0; i < 300 && (sil ? tx_silence : flp_send) !== v; i++) step(1);
    if ((sil ? tx_silence : flp_send) !== v) begin
      miscompares++;
      $display("[ERR] wait expected %b seen %b", v, ~v);
      print_verdict();
    end
  endtask : wsig
  function automatic logic [1:0] best(input logic [3:0] c);
    best = c[3] ? 2'b11 : c[2] ? 2'b10 : c[1] ? 2'b01 : 2'b00;
  endfunction : best
  always @(posedge clk) begin
    rd_d <= reg_rd;
    tx_activity <= 1'($urandom);
    if (rd_d) chk("reg_rdata", reg_rdata & mq.pop_front(), eq.pop_front());
  end
  // ------
  // Main sequence
  // ------
  initial begin
    int i;
    logic [1:0] r;
    logic [15:0] advs [5];
    void'($urandom(32'hab9c3a37));
    strap_abilities = 4'($urandom) | 4'h1;
    advs = '{{7'h0, strap_abilities, 5'h01}, 16'h01e1, 16'h00e1, 16'h0061, 16'h0021};
    mode = 3'd1;
    repeat (10) @(posedge clk);
    rstn <= 1;
    repeat (3) @(posedge clk);
    rd(PALS_OFF_STATUS, PALS_STATUS_CAPS, 16'hffff);
    rd(PALS_OFF_ADVERT, advs[0], 16'hffff);
    rd(PALS_OFF_CONTROL, 16'h1000, 16'hfdff);
    rd(PALS_OFF_EXPANSION, PALS_EXP_LOCAL_NP, 16'hffff);
    rd(PALS_OFF_RESULT, 16'h0000, 16'hffff);
    rd(8'h00, 16'h0000, 16'hffff);
    $display("test boot done");
    for (i = 0; i < 5; i++) begin
      adv = advs[i];
      dly <= 5'(i * 6);
      if (i > 0) begin
        wr(PALS_OFF_ADVERT, adv);
        wr(PALS_OFF_CONTROL, 16'h1200);
        wsig(1, 1);
      end
      wsig(0, 1);
      chk("flp_word", flp_word, adv);
      wsig(0, 0);
      r = best(adv[8:5] & pw[8:5]);
      step(2);
      chk("mode", {14'h0, link_speed_100, link_full_duplex}, {14'h0, r});
      rd(PALS_OFF_RESULT, {11'h0, 1'b1, 1'b0, r[0], r[1], 1'b0}, 16'h0016);
      rd(PALS_OFF_PARTNER, pw, 16'hffff);
      rd(PALS_OFF_STATUS, 16'h7879, 16'hfffb);
      rd(PALS_OFF_EXPANSION, 16'h0007, 16'h001f);
      rd(PALS_OFF_CONTROL, 16'h1000, 16'hffff);
    end
    $display("test negotiation done");
    wr(PALS_OFF_ADVERT, 16'h01e1);
    for (i = 0; i < 3; i++) begin
      wr(PALS_OFF_CONTROL, 16'h0000);
      mode <= 3'(2 + i);
      if (i == 2) step(80);
      wr(PALS_OFF_CONTROL, 16'h1000);
      if (i < 2) begin
        wsig(0, 1);
        wsig(0, 0);
        step(4);
        rd(PALS_OFF_PARTNER, i ? 16'h0021 : 16'h0081, 16'hffff);
        rd(PALS_OFF_EXPANSION, 16'h0004, 16'h0015);
        rd(PALS_OFF_RESULT, {11'h0, 1'b1, 2'b00, ~i[0], 1'b0}, 16'h0016);
        chk("led", {15'h0, i ? slow_link_indicator_n : fast_link_indicator_n}, 16'h0);
        if (i == 1) begin
          mode <= 3'd0;
          wsig(1, 1);
          wsig(0, 1);
        end
      end else begin
        step(80);
        rd(PALS_OFF_EXPANSION, 16'h0010, 16'h0010);
      end
    end
    $display("test parallel detect done");
    mode <= 3'd0;
    for (i = 0; i < 2; i++) begin
      wr(PALS_OFF_CONTROL, i ? 16'h0000 : 16'h2100);
      step(2);
      chk("forced", {14'h0, link_speed_100, link_full_duplex}, i ? 16'h0 : 16'h3);
      rd(PALS_OFF_RESULT, i ? 16'h0 : 16'h0006, 16'h0006);
    end
    @(posedge clk) pkt <= 1;
    @(posedge clk) pkt <= 0;
    step(5);
    chk("packet_led", {15'h0, slow_link_indicator_n}, 16'h0);
    step(2);
    $display("test forced done");
    print_verdict();
  end
endmodule : tb
